// File: hdl/arec_top.sv
// What this block does
// R1: dac level field: 11 4.096V, 10 2.048V default, 01 1.024V, 00 off.
// R2: dac source bit: set uses internal level, clear uses supply; clear default.
// R3: five-bit initial dac code drives dac output, default eight.
// R4: falling-edge enable set makes detector trigger on falls; set by default.
// R5: rising-edge enable set makes detector trigger on rises; set by default.
// R6: adc level field: 11 4.096V, 10 2.048V, 01 1.024V default, 00 off.
// R7: adc source bit: set uses internal level (default), clear uses supply.
// R8: both enables trigger either edge, none never; reserved bits stay zero.
module arec_top
    import arec_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic int_pin,
    output logic [1:0] dac_ref_level_sel,
    output logic dac_ref_source_sel,
    output logic [4:0] dac_init_code,
    output logic [1:0] adc_ref_level_sel,
    output logic adc_ref_source_sel,
    output logic edge_trig
);
    ////////////////////////////////////////////////////////////////////////
    logic [7:0] dac_cfg_q;
    logic [7:0] edge_cfg_q;
    logic edge_flag_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic wstrb0_q;
    logic aw_held_q;
    logic w_held_q;
    logic trig;
    logic wr_fire;
    logic flag_clr;

    // one code per register slot; a single decode keeps write and read maps in step
    typedef enum logic [1:0] {
        AREC_SEL_NONE = 2'b00,
        AREC_SEL_DAC = 2'b01,
        AREC_SEL_EDGE = 2'b10,
        AREC_SEL_STAT = 2'b11
    } arec_sel_t;

    // address decode shared by the write answer, the write strobes and the read mux
    function automatic arec_sel_t reg_sel(input logic [ADDR_W-1:0] addr);
        arec_sel_t sel;
        if (addr == ADDR_DAC_CFG) begin
            sel = AREC_SEL_DAC;
        end else if (addr == ADDR_EDGE_CFG) begin
            sel = AREC_SEL_EDGE;
        end else if (addr == ADDR_EDGE_STAT) begin
            sel = AREC_SEL_STAT;
        end else begin
            sel = AREC_SEL_NONE;
        end
        return sel;
    endfunction

    arec_sel_t wr_sel;
    arec_sel_t rd_sel;

    // the write decode looks at the held address, the read decode at the live one
    assign wr_sel = reg_sel(awaddr_q);
    assign rd_sel = reg_sel(s_axi_araddr);

    // write side holds address and data separately, either may come first
    assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            aw_held_q <= 1'b0;
            awaddr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            w_held_q <= 1'b0;
            wdata_q <= '0;
            wstrb0_q <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb0_q <= s_axi_wstrb[0];
        end else if (wr_fire) begin
            w_held_q <= 1'b0;
        end
    end

    // ready only while the holding slot is empty; this throttles one write
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready);
        end
    end

    // response: only an unmapped address answers slverr; a status write answers okay
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            if (wr_sel != AREC_SEL_NONE) begin
                s_axi_bresp <= RESP_OKAY;
            end else begin
                s_axi_bresp <= RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers; only byte lane 0 carries data
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            dac_cfg_q <= DAC_CFG_RST; // R1 R2 R3
        end else if (wr_fire && wstrb0_q && wr_sel == AREC_SEL_DAC) begin
            dac_cfg_q <= wdata_q[7:0] & DAC_CFG_MASK; // R1 R2 R3
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            edge_cfg_q <= EDGE_CFG_RST; // R4 R5 R6 R7
        end else if (wr_fire && wstrb0_q && wr_sel == AREC_SEL_EDGE) begin
            edge_cfg_q <= wdata_q[7:0] & EDGE_CFG_MASK; // R8
        end
    end

    assign flag_clr = wr_fire && wstrb0_q && wr_sel == AREC_SEL_STAT && wdata_q[0];

    // sticky trigger flag, write one to clear; a new trigger wins over clear
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            edge_flag_q <= 1'b0;
        end else if (trig) begin
            edge_flag_q <= 1'b1;
        end else if (flag_clr) begin
            edge_flag_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    arec_edge_det u_det (
        .clock(clock),
        .rstn(rstn),
        .pin(int_pin),
        .fall_en(edge_cfg_q[FALL_EN_BIT]),
        .rise_en(edge_cfg_q[RISE_EN_BIT]),
        .trig(trig)
    );

    // outputs straight from flops, one cycle after the config register
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            dac_ref_level_sel <= DAC_CFG_RST[DAC_LVL_HI:DAC_LVL_LO];
            dac_ref_source_sel <= DAC_CFG_RST[DAC_SRC_BIT];
            dac_init_code <= DAC_CFG_RST[DAC_CODE_HI:DAC_CODE_LO];
            adc_ref_level_sel <= EDGE_CFG_RST[ADC_LVL_HI:ADC_LVL_LO];
            adc_ref_source_sel <= EDGE_CFG_RST[ADC_SRC_BIT];
            edge_trig <= 1'b0;
        end else begin
            dac_ref_level_sel <= dac_cfg_q[DAC_LVL_HI:DAC_LVL_LO]; // R1
            dac_ref_source_sel <= dac_cfg_q[DAC_SRC_BIT]; // R2
            dac_init_code <= dac_cfg_q[DAC_CODE_HI:DAC_CODE_LO]; // R3
            adc_ref_level_sel <= edge_cfg_q[ADC_LVL_HI:ADC_LVL_LO]; // R6
            adc_ref_source_sel <= edge_cfg_q[ADC_SRC_BIT]; // R7
            edge_trig <= trig; // R4 R5
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read channel, one read at a time
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_rvalid) begin
            s_axi_arready <= 1'b0;
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            if (rd_sel == AREC_SEL_DAC) begin
                s_axi_rdata <= {24'h000000, dac_cfg_q};
            end else if (rd_sel == AREC_SEL_EDGE) begin
                s_axi_rdata <= {24'h000000, edge_cfg_q}; // R8
            end else if (rd_sel == AREC_SEL_STAT) begin
                s_axi_rdata <= {31'h00000000, edge_flag_q};
            end else begin
                s_axi_rdata <= '0;
                s_axi_rresp <= RESP_SLVERR;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end
endmodule

// File: hdl/arec_pkg.sv
package arec_pkg;
    // register byte addresses on the axi4-lite bus
    localparam logic [3:0] ADDR_DAC_CFG = 4'h0;
    localparam logic [3:0] ADDR_EDGE_CFG = 4'h4;
    localparam logic [3:0] ADDR_EDGE_STAT = 4'h8;
    localparam int ADDR_W = 4;

    // dac_startup_config layout
    localparam int DAC_LVL_HI = 7;
    localparam int DAC_LVL_LO = 6;
    localparam int DAC_SRC_BIT = 5;
    localparam int DAC_CODE_HI = 4;
    localparam int DAC_CODE_LO = 0;
    localparam logic [7:0] DAC_CFG_RST = 8'h88;
    localparam logic [7:0] DAC_CFG_MASK = 8'hFF;

    // edge_detect_adc_ref_config layout
    localparam int FALL_EN_BIT = 6;
    localparam int RISE_EN_BIT = 5;
    localparam int ADC_LVL_HI = 4;
    localparam int ADC_LVL_LO = 3;
    localparam int ADC_SRC_BIT = 2;
    localparam logic [7:0] EDGE_CFG_RST = 8'h6C;
    localparam logic [7:0] EDGE_CFG_MASK = 8'h7C;

    // reference level codes
    typedef enum logic [1:0] {
        AREC_REF_OFF = 2'b00,
        AREC_REF_1V024 = 2'b01,
        AREC_REF_2V048 = 2'b10,
        AREC_REF_4V096 = 2'b11
    } arec_ref_lvl_t;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// File: hdl/arec_edge_det.sv
// three-stage input synchroniser and qualified edge detector
module arec_edge_det
    import arec_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic pin,
    input wire logic fall_en,
    input wire logic rise_en,
    output logic trig
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;

    // first stage feeds only the second
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // accepted level changes only when stages two and three agree
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            level_q <= 1'b0;
        end else if (s2_q == s3_q) begin
            level_q <= s3_q;
        end
    end

    // enabled edges, both enables give either edge, none gives nothing
    always_comb begin
        trig = 1'b0;
        if (s2_q == s3_q && s3_q != level_q) begin
            trig = s3_q ? rise_en : fall_en; // R4 R5 R8
        end
    end
endmodule

// File: dv/arec_top_props.sv
// protocol and config-output checks seen from the top module's pins only
module arec_top_props (
    input wire logic clock,
    input wire logic rstn,
    input wire logic s_axi_awready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic int_pin,
    input wire logic [1:0] dac_ref_level_sel,
    input wire logic dac_ref_source_sel,
    input wire logic [4:0] dac_init_code,
    input wire logic [1:0] adc_ref_level_sel,
    input wire logic adc_ref_source_sel,
    input wire logic edge_trig
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rstn);
    // config pins may only move right after a write answer, never on their own
    property p_dac; !$stable({dac_ref_level_sel, dac_ref_source_sel, dac_init_code}) |-> $past(s_axi_bvalid); endproperty
    a_dac: assert property (p_dac) else $error("dac config pins moved without a write");
    property p_adc; !$stable({adc_ref_level_sel, adc_ref_source_sel}) |-> $past(s_axi_bvalid); endproperty
    a_adc: assert property (p_adc) else $error("adc config pins moved without a write");
    // a trigger needs a real pin change a few cycles earlier and lasts one cycle
    property p_cause; edge_trig |-> $past(int_pin, 2) != $past(int_pin, 8); endproperty
    a_cause: assert property (p_cause) else $error("trigger without pin edge");
    property p_pulse; edge_trig |=> !edge_trig; endproperty
    a_pulse: assert property (p_pulse) else $error("trigger longer than one cycle");
    property p_rdz; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
    a_rdz: assert property (p_rdz) else $error("read data above the byte not zero");
    property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rlat: assert property (p_rlat) else $error("read answer not next cycle");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read answer dropped early");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_bhold: assert property (p_bhold) else $error("write answer dropped early");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind arec_top arec_top_props arec_top_props_i (.clock, .rstn, .s_axi_awready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .int_pin, .dac_ref_level_sel, .dac_ref_source_sel, .dac_init_code,
    .adc_ref_level_sel, .adc_ref_source_sel, .edge_trig);

// File: dv/arec_top_tb.sv
module arec_top_tb
    import arec_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic int_pin, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, dac_ref_level_sel, adc_ref_level_sel;
    logic dac_ref_source_sel, adc_ref_source_sel, edge_trig;
    logic [4:0] dac_init_code;
    logic [7:0] dac_m, edg_m, v;
    int errors, n_checks, nr, nf;
    int cyc = 0;
    bit lazy = 0;
    arec_top arec_top_i (.clock, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .int_pin, .dac_ref_level_sel,
        .dac_ref_source_sel, .dac_init_code, .adc_ref_level_sel, .adc_ref_source_sel, .edge_trig);
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lf(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // aw and w offered together, each dropped once its own ready is seen
    task wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
        bit aw;
        bit w;
        aw = 0;
        w = 0;
        @(posedge clock); // a quiet edge keeps bready from being driven twice in one step
        s_axi_awaddr <= a;
        s_axi_wdata <= {seed[31:8], d}; // upper bits must be ignored
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= !lazy;
        while (!(aw && w)) begin
            @(posedge clock);
            aw |= s_axi_awready;
            w |= s_axi_wready;
            s_axi_awvalid <= !aw;
            s_axi_wvalid <= !w;
        end
        // a lazy master raises bready only once it has seen the answer
        forever begin
            @(posedge clock);
            if (s_axi_bvalid && s_axi_bready) begin
                break;
            end
            if (s_axi_bvalid) begin
                s_axi_bready <= 1;
            end
        end
        s_axi_bready <= 0;
        chk(32'(s_axi_bresp), 32'(er));
    endtask
    task rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clock); // a quiet edge keeps rready from being driven twice in one step
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= !lazy;
        do @(posedge clock); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        forever begin
            @(posedge clock);
            if (s_axi_rvalid && s_axi_rready) begin
                break;
            end
            if (s_axi_rvalid) begin
                s_axi_rready <= 1;
            end
        end
        s_axi_rready <= 0;
        chk(s_axi_rdata, e);
        chk(32'(s_axi_rresp), 32'(er));
    endtask
    // pins lag the register by a cycle, so only call this after a read
    task outs;
        chk(32'({dac_ref_level_sel, dac_ref_source_sel, dac_init_code}), 32'(dac_m));
        chk(32'({adc_ref_level_sel, adc_ref_source_sel}), 32'(edg_m[4:2]));
    endtask
    task pins(input logic lvl, output int n);
        n = 0;
        int_pin <= lvl;
        repeat (12) begin
            @(posedge clock);
            n += int'(edge_trig === 1'b1);
        end
    endtask
    task report_and_stop;
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 0;
        forever #25 clock = ~clock;
    end
    // hang guard, far above the few hundred cycles the tests need
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            report_and_stop;
        end
    end
    initial begin
        {rstn, int_pin, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
        s_axi_wstrb = 4'hF;
        seed = 32'h6D1C;
        dac_m = 8'h88; // level 10, supply source, code 8
        edg_m = 8'h6C; // both edges, level 01, internal source
        repeat (2) @(posedge clock);
        rstn <= 1;
        @(posedge clock);
        rd(ADDR_DAC_CFG, 32'(dac_m), RESP_OKAY);
        rd(ADDR_EDGE_CFG, 32'(edg_m), RESP_OKAY);
        outs;
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            seed = lf(seed);
            v = {i[1:0], seed[5:0]};
            dac_m = v;
            wr(ADDR_DAC_CFG, v, RESP_OKAY);
            rd(ADDR_DAC_CFG, 32'(dac_m), RESP_OKAY);
            v = {seed[15:13], i[1:0], seed[18:16]};
            edg_m = v & 8'h7C;
            wr(ADDR_EDGE_CFG, v, RESP_OKAY);
            rd(ADDR_EDGE_CFG, 32'(edg_m), RESP_OKAY);
            outs;
        end
        $display("test config done");
        lazy = 1; // answers must stand while ready is held back
        wr(4'hC, 8'h55, RESP_SLVERR);
        rd(4'hC, 32'h0, RESP_SLVERR);
        lazy = 0;
        rd(ADDR_DAC_CFG, 32'(dac_m), RESP_OKAY);
        $display("test unmapped done");
        // every enable pair, one rise then one fall each
        for (int i = 0; i < 4; i++) begin
            edg_m = {1'b0, i[1:0], 5'h0C};
            wr(ADDR_EDGE_CFG, edg_m, RESP_OKAY);
            pins(1'b1, nr);
            pins(1'b0, nf);
            chk(32'(nr), 32'(i[0]));
            chk(32'(nf), 32'(i[1]));
        end
        $display("test edges done");
        // sticky flag from the triggers above, cleared by writing one
        rd(ADDR_EDGE_STAT, 32'h1, RESP_OKAY);
        wr(ADDR_EDGE_STAT, 8'h01, RESP_OKAY);
        rd(ADDR_EDGE_STAT, 32'h0, RESP_OKAY);
        // lane 0 strobe low writes nothing but still answers okay
        s_axi_wstrb <= 4'hE;
        wr(ADDR_DAC_CFG, ~dac_m, RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        rd(ADDR_DAC_CFG, 32'(dac_m), RESP_OKAY);
        outs;
        $display("test status done");
        report_and_stop;
    end
endmodule
